/* File: dmae_top.sv */
/*
 * DMA controller error, priority, interrupt vector and bus hold control for four channels.
 * Assumes the transfer engine reports errors, operands and status flags as levels and pulses
 * synchronous to CLK_SYS, and that the board decoder presents register accesses at the
 * controller's internal offsets.
 */
// What this block does
// - Error code bits 4..0 give none, configuration, timing error; 00011 reserved.
// - Address, bus and count errors encode as 001rr, 010rr and 011rr.
// - External abort records 10000, software abort records 10001.
// - Low code bits: 01 memory, 10 device address, 11 base register.
// - Error register is read only; bits 7..5 read zero.
// - Clearing the channel error flag clears the error code to none.
// - Each channel holds a two-bit priority, levels 0 to 3, 3 highest.
// - Pending DMA requests are served highest programmed priority first.
// - Pending interrupts are serviced highest channel priority first.
// - Requesters sharing the top level are served in round-robin order.
// - Each channel has an eight-bit normal and an eight-bit error vector.
// - Acknowledge passes through only when its level matches the programmed level 1-7.
// - A passed acknowledge returns the winning channel's vector on data bits 7..0.
// - Channel interrupts when enabled and complete, block done, or line transition flagged on a control line set as interrupt.
// - Normal vector is returned unless the channel error flag is set.
// - All vectors reset to 0x0F.
// - Port one uses channel 1, port two uses channel 3 for status interrupts.
// - In hold mode the bus is kept until a full interval passes without request.
// - Sample interval is two to the power burst plus bandwidth plus 5 clocks.
// - The sample interval counts controller clocks of 8 MHz.
// - One shared hold control setting serves all four channels.
// - Burst field bits 3..2 mean 16, 32, 64 or 128 clocks.
// - Bandwidth field bits 1..0 mean 50, 25, 12.5 or 6.25 percent.
// - Hold control bits 7..4 are reserved and read zero.
`timescale 1ns/1ps
`include "dmae_consts.svh"
module dmae_top #(
	parameter int NCH       = 4,
	parameter int SYS_HZ    = `DMAE_SYS_CLK_HZ,
	parameter int CTRL_HZ   = `DMAE_CTRL_CLK_HZ,
	parameter int PORTA_CH  = 1,
	parameter int PORTB_CH  = 3
) (
	// Clock and reset.
	input  wire logic                         CLK_SYS,
	input  wire logic                         SYS_RST,
	// Register access.
	input  wire logic [7:0]                   REG_ADDR,
	input  wire logic                         REG_WR,
	input  wire logic                         REG_RD,
	input  wire logic [7:0]                   REG_WDATA,
	output logic [7:0]                        REG_RDATA,
	output logic                              REG_ACK,
	// Channel status from the transfer engine.
	input  wire logic [NCH-1:0]               CH_ERR_FLAG,
	input  wire dmae_pkg::dmae_err_s [NCH-1:0] CH_ERR_CAUSE,
	input  wire dmae_pkg::dmae_irq_src_s [NCH-1:0] CH_IRQ_SRC,
	input  wire logic [NCH-1:0]               CH_HOLD_MODE,
	// DMA request arbitration.
	input  wire logic [NCH-1:0]               DMA_REQ,
	input  wire logic                         SERVE_READY,
	input  wire logic                         OPERAND_DONE,
	output logic                              GRANT_VALID,
	output logic [1:0]                        GRANT_CH,
	// Bus hold.
	output logic                              BUS_HOLD,
	output logic                              BUS_RELEASE,
	// Interrupt request and acknowledge.
	input  wire logic [2:0]                   BOARD_IRQ_LEVEL,
	input  wire logic                         IACK_STROBE,
	input  wire logic [2:0]                   IACK_LEVEL,
	output logic                              IRQ_PENDING,
	output logic [7:0]                        IACK_DATA,
	output logic                              IACK_DONE,
	output logic [1:0]                        IACK_CH,
	output logic                              PORTA_STATUS_IRQ,
	output logic                              PORTB_STATUS_IRQ
);
	import dmae_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register storage.

	logic [4:0]       err_code_q [NCH];
	logic [1:0]       prio_q     [NCH];
	logic [7:0]       nvec_q     [NCH];
	logic [7:0]       evec_q     [NCH];
	logic [NCH-1:0]   err_flag_q;
	logic [1:0]       burst_q;
	logic [1:0]       bw_q;
	logic [1:0]       sel_ch;
	logic [5:0]       sel_ofs;
	logic             is_hold_ctrl;
	logic [NCH*2-1:0] prio_flat;

	assign sel_ch       = REG_ADDR[7:6];
	assign sel_ofs      = REG_ADDR[5:0];
	assign is_hold_ctrl = (REG_ADDR == `DMAE_ADDR_HOLD_CTRL);

	function automatic logic [4:0] encode_err(input dmae_err_s e);
		case (e.cause)
			DMAE_CAUSE_NONE:      encode_err = `DMAE_EC_NONE;
			DMAE_CAUSE_CONFIG:    encode_err = `DMAE_EC_CONFIG;
			DMAE_CAUSE_TIMING:    encode_err = `DMAE_EC_TIMING;
			DMAE_CAUSE_ADDR:      encode_err = {`DMAE_EC_CLASS_ADDR, e.target};
			DMAE_CAUSE_BUS:       encode_err = {`DMAE_EC_CLASS_BUS, e.target};
			DMAE_CAUSE_COUNT:     encode_err = {`DMAE_EC_CLASS_COUNT, e.target};
			DMAE_CAUSE_EXT_ABORT: encode_err = `DMAE_EC_EXT_ABORT;
			DMAE_CAUSE_SW_ABORT:  encode_err = `DMAE_EC_SW_ABORT;
			default:              encode_err = `DMAE_EC_NONE;
		endcase
	endfunction : encode_err

	////////////////////////////////////////////////////////////////////////////////
	// Error code capture.
	// A low flag wins over everything, so a cleared error never leaves a stale code behind.
	// The cause is taken only in the cycle the flag rises; later changes of the cause are ignored.

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			err_flag_q <= '0;
			for (int i = 0; i < NCH; i++) begin
				err_code_q[i] <= `DMAE_EC_NONE;
			end
		end else begin
			err_flag_q <= CH_ERR_FLAG;
			for (int i = 0; i < NCH; i++) begin
				if (!CH_ERR_FLAG[i]) begin
					err_code_q[i] <= `DMAE_EC_NONE;
				end else if (!err_flag_q[i]) begin
					err_code_q[i] <= encode_err(CH_ERR_CAUSE[i]);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Writable registers.
	// Hold control keeps only its four defined bits; the reserved upper bits are never stored.

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			burst_q <= 2'(`DMAE_HOLD_CTRL_RESET >> `DMAE_BURST_LSB);
			bw_q    <= 2'(`DMAE_HOLD_CTRL_RESET);
			for (int i = 0; i < NCH; i++) begin
				prio_q[i] <= `DMAE_PRIO_RESET;
				nvec_q[i] <= `DMAE_VECTOR_RESET;
				evec_q[i] <= `DMAE_VECTOR_RESET;
			end
		end else if (REG_WR) begin
			if (is_hold_ctrl) begin
				burst_q <= REG_WDATA[`DMAE_BURST_MSB:`DMAE_BURST_LSB];
				bw_q    <= REG_WDATA[`DMAE_BW_MSB:`DMAE_BW_LSB];
			end else begin
				case (sel_ofs)
					`DMAE_OFS_PRIORITY:   prio_q[sel_ch] <= REG_WDATA[`DMAE_PRIO_MSB:0];
					`DMAE_OFS_NORMAL_VEC: nvec_q[sel_ch] <= REG_WDATA;
					`DMAE_OFS_ERROR_VEC:  evec_q[sel_ch] <= REG_WDATA;
					default: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read port; the error code register ignores writes.
	// Read data is zero outside an acknowledge, so a shared read bus sees nothing stray.

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			REG_RDATA <= 8'h00;
			REG_ACK   <= 1'b0;
		end else begin
			REG_ACK <= REG_RD | REG_WR;
			if (REG_RD) begin
				if (is_hold_ctrl) begin
					REG_RDATA <= {4'h0, burst_q, bw_q};
				end else begin
					case (sel_ofs)
						`DMAE_OFS_ERR_CODE:   REG_RDATA <= {3'h0, err_code_q[sel_ch]};
						`DMAE_OFS_PRIORITY:   REG_RDATA <= {6'h00, prio_q[sel_ch]};
						`DMAE_OFS_NORMAL_VEC: REG_RDATA <= nvec_q[sel_ch];
						`DMAE_OFS_ERROR_VEC:  REG_RDATA <= evec_q[sel_ch];
						default:              REG_RDATA <= 8'h00;
					endcase
				end
			end else begin
				REG_RDATA <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// DMA request arbitration.

	logic       dma_win_valid;
	logic [1:0] dma_win_idx;
	logic       dma_advance;

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			prio_flat[i*2 +: 2] = prio_q[i];
		end
	end

	// The engine takes a grant only when it is ready, and the round-robin pointer moves only then,
	// so a cycle in which the engine is busy does not cost a tied channel its turn.
	assign dma_advance = SERVE_READY & dma_win_valid;

	dmae_rr_arb #(
		.N  (NCH),
		.PW (2)
	) u_dma_arb (
		.clk       (CLK_SYS),
		.rst       (SYS_RST),
		.req       (DMA_REQ),
		.prio      (prio_flat),
		.advance   (dma_advance),
		.win_valid (dma_win_valid),
		.win_idx   (dma_win_idx)
	);

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			GRANT_VALID <= 1'b0;
			GRANT_CH    <= 2'h0;
		end else begin
			GRANT_VALID <= dma_advance;
			if (dma_advance) begin
				GRANT_CH <= dma_win_idx;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus hold with the controller clock derived as a fractional enable.
	// The accumulator adds the controller rate each cycle and wraps at the system rate, so ticks
	// arrive every 12 or 13 cycles and average exactly the controller clock without drift.
	// The interval timer counts these ticks, not system cycles.

	localparam int ACC_W = $clog2(SYS_HZ) + 1;
	logic [ACC_W-1:0] phase_q;
	logic             ctrl_tick_q;
	logic             hold_en;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			phase_q     <= '0;
			ctrl_tick_q <= 1'b0;
		end else if (phase_q + ACC_W'(CTRL_HZ) >= ACC_W'(SYS_HZ)) begin
			phase_q     <= phase_q + ACC_W'(CTRL_HZ) - ACC_W'(SYS_HZ);
			ctrl_tick_q <= 1'b1;
		end else begin
			phase_q     <= phase_q + ACC_W'(CTRL_HZ);
			ctrl_tick_q <= 1'b0;
		end
	end

	// One shared setting serves every channel; any channel in hold mode arms the timer.
	assign hold_en = |CH_HOLD_MODE;

	dmae_hold_timer #(
		.CW (12)
	) u_hold (
		.clk              (CLK_SYS),
		.rst              (SYS_RST),
		.tick             (ctrl_tick_q),
		.hold_en          (hold_en),
		.operand_done     (OPERAND_DONE),
		.any_req          (|DMA_REQ),
		.burst_time_field (burst_q),
		.bandwidth_field  (bw_q),
		.holding_q        (BUS_HOLD),
		.release_q        (BUS_RELEASE)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt requests, arbitration and acknowledge.
	// The interrupt arbiter keeps its own pointer, so DMA service never shifts the interrupt order.

	logic [NCH-1:0] irq_req;
	logic           irq_win_valid;
	logic [1:0]     irq_win_idx;
	logic           iack_match;

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			irq_req[i] = CH_IRQ_SRC[i].channel_irq_enable &
				(CH_IRQ_SRC[i].operation_complete_flag | CH_IRQ_SRC[i].block_termination_flag |
				(CH_IRQ_SRC[i].peripheral_line_transition_flag &
				CH_IRQ_SRC[i].peripheral_control_line_is_irq));
		end
	end

	// An acknowledge at another level is left unanswered, and level zero never matches.
	assign iack_match = IACK_STROBE && (BOARD_IRQ_LEVEL != 3'h0) && (IACK_LEVEL == BOARD_IRQ_LEVEL)
		&& irq_win_valid;

	dmae_rr_arb #(
		.N  (NCH),
		.PW (2)
	) u_irq_arb (
		.clk       (CLK_SYS),
		.rst       (SYS_RST),
		.req       (irq_req),
		.prio      (prio_flat),
		.advance   (iack_match),
		.win_valid (irq_win_valid),
		.win_idx   (irq_win_idx)
	);

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			IRQ_PENDING      <= 1'b0;
			PORTA_STATUS_IRQ <= 1'b0;
			PORTB_STATUS_IRQ <= 1'b0;
		end else begin
			// Each port's status interrupt mirrors the request of the channel that the port uses.
			IRQ_PENDING      <= |irq_req;
			PORTA_STATUS_IRQ <= irq_req[PORTA_CH];
			PORTB_STATUS_IRQ <= irq_req[PORTB_CH];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			IACK_DATA <= 8'h00;
			IACK_DONE <= 1'b0;
			IACK_CH   <= 2'h0;
		end else begin
			// The vector follows the live error flag, so an error raised after the request returns the error vector.
			IACK_DONE <= iack_match;
			if (iack_match) begin
				IACK_CH <= irq_win_idx;
				if (CH_ERR_FLAG[irq_win_idx]) begin
					IACK_DATA <= evec_q[irq_win_idx];
				end else begin
					IACK_DATA <= nvec_q[irq_win_idx];
				end
			end
		end
	end

endmodule : dmae_top

/* File: dmae_consts.svh */
/*
 * Offsets, field positions, reset values, error codes and timing figures of the DMA control block.
 * Assumes inclusion by bare name from the modules and the bench that need these values.
 */
`ifndef DMAE_CONSTS_SVH
`define DMAE_CONSTS_SVH

// Register offsets within a channel window, whose channel is picked by address bits 7..6, and the full hold control address.
`define DMAE_OFS_ERR_CODE     6'h01
`define DMAE_OFS_PRIORITY     6'h2D
`define DMAE_OFS_NORMAL_VEC   6'h25
`define DMAE_OFS_ERROR_VEC    6'h27
`define DMAE_ADDR_HOLD_CTRL   8'hFF

// Field positions.
`define DMAE_ERR_CODE_MSB     4
`define DMAE_PRIO_MSB         1
`define DMAE_BURST_MSB        3
`define DMAE_BURST_LSB        2
`define DMAE_BW_MSB           1
`define DMAE_BW_LSB           0

// Reset values.
`define DMAE_VECTOR_RESET     8'h0F
`define DMAE_PRIO_RESET       2'h0
`define DMAE_HOLD_CTRL_RESET  4'h0

// Error codes; the three class codes take the register code in their low two bits.
`define DMAE_EC_NONE          5'h00
`define DMAE_EC_CONFIG        5'h01
`define DMAE_EC_TIMING        5'h02
`define DMAE_EC_CLASS_ADDR    3'h1
`define DMAE_EC_CLASS_BUS     3'h2
`define DMAE_EC_CLASS_COUNT   3'h3
`define DMAE_EC_EXT_ABORT     5'h10
`define DMAE_EC_SW_ABORT      5'h11
`define DMAE_RR_MEMORY        2'h1
`define DMAE_RR_DEVICE        2'h2
`define DMAE_RR_BASE          2'h3

// Sample interval exponent offset and controller time base.
`define DMAE_SAMPLE_EXP_BASE  4'h5
`define DMAE_SYS_CLK_HZ       100000000
`define DMAE_CTRL_CLK_HZ      8000000

`endif

/* File: dmae_pkg.sv */
/*
 * Types shared by the DMA control block: error causes and the error report carrier.
 * Assumes the constants header is available on the include path.
 */
package dmae_pkg;

	typedef enum logic [2:0] {
		DMAE_CAUSE_NONE,
		DMAE_CAUSE_CONFIG,
		DMAE_CAUSE_TIMING,
		DMAE_CAUSE_ADDR,
		DMAE_CAUSE_BUS,
		DMAE_CAUSE_COUNT,
		DMAE_CAUSE_EXT_ABORT,
		DMAE_CAUSE_SW_ABORT
	} dmae_cause_e;

	typedef logic [1:0] dmae_rr_t;

	typedef struct packed {
		dmae_cause_e cause;
		dmae_rr_t    target;
	} dmae_err_s;

	typedef struct packed {
		logic operation_complete_flag;
		logic block_termination_flag;
		logic peripheral_line_transition_flag;
		logic peripheral_control_line_is_irq;
		logic channel_irq_enable;
	} dmae_irq_src_s;

endpackage : dmae_pkg

/* File: dmae_rr_arb.sv */
/*
 * Priority arbiter with round robin among requesters that share the top level.
 * Assumes priorities are stable in the cycle where advance is raised.
 */
`timescale 1ns/1ps
module dmae_rr_arb #(
	parameter int N  = 4,
	parameter int PW = 2,
	parameter int IW = $clog2(N)
) (
	// Clock and reset.
	input  wire logic            clk,
	input  wire logic            rst,
	// Requests and levels.
	input  wire logic [N-1:0]    req,
	input  wire logic [N*PW-1:0] prio,
	input  wire logic            advance,
	// Winner.
	output logic                 win_valid,
	output logic [IW-1:0]        win_idx
);
	logic [IW-1:0] ptr_q;
	logic [PW-1:0] top;
	int            c;

	always_comb begin
		top       = '0;
		c         = 0;
		win_valid = 1'b0;
		win_idx   = '0;
		for (int i = 0; i < N; i++) begin
			if (req[i] && prio[i*PW +: PW] >= top) begin
				top = prio[i*PW +: PW];
			end
		end
		// Search starts just after the last winner, so equal levels take turns.
		for (int k = 1; k <= N; k++) begin
			c = (int'(ptr_q) + k) % N;
			if (!win_valid && req[c] && prio[c*PW +: PW] == top) begin
				win_valid = 1'b1;
				win_idx   = IW'(c);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ptr_q <= IW'(N - 1);
		end else if (advance && win_valid) begin
			ptr_q <= win_idx;
		end
	end

endmodule : dmae_rr_arb

/* File: dmae_hold_timer.sv */
/*
 * Bus hold timer for cycle steal with hold: keeps the bus after each operand
 * and releases it after one full sample interval without a request.
 * Assumes tick is a one-cycle enable at the controller clock rate.
 */
`timescale 1ns/1ps
`include "dmae_consts.svh"
module dmae_hold_timer #(
	parameter int CW = 12
) (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       tick,
	// Control.
	input  wire logic       hold_en,
	input  wire logic       operand_done,
	input  wire logic       any_req,
	input  wire logic [1:0] burst_time_field,
	input  wire logic [1:0] bandwidth_field,
	// Status.
	output logic            holding_q,
	output logic            release_q
);
	typedef enum logic [1:0] {
		HT_IDLE,
		HT_SAMPLE,
		HT_WAIT
	} dmae_ht_e;

	dmae_ht_e      state_q;
	logic [CW-1:0] cnt_q;
	logic [3:0]    expo;
	logic [CW-1:0] limit;

	always_comb begin
		expo  = 4'({2'h0, burst_time_field}) + 4'({2'h0, bandwidth_field}) + `DMAE_SAMPLE_EXP_BASE;
		limit = CW'(1) << expo;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q   <= HT_IDLE;
			cnt_q     <= '0;
			holding_q <= 1'b0;
			release_q <= 1'b0;
		end else begin
			release_q <= 1'b0;
			if (!hold_en) begin
				state_q   <= HT_IDLE;
				holding_q <= 1'b0;
			end else begin
				case (state_q)
					HT_IDLE: begin
						if (operand_done) begin
							state_q   <= HT_SAMPLE;
							cnt_q     <= '0;
							holding_q <= 1'b1;
						end
					end
					HT_SAMPLE: begin
						if (any_req) begin
							state_q <= HT_WAIT;
						end else if (tick) begin
							if (cnt_q == limit - CW'(1)) begin
								state_q   <= HT_IDLE;
								holding_q <= 1'b0;
								release_q <= 1'b1;
							end else begin
								cnt_q <= cnt_q + CW'(1);
							end
						end
					end
					HT_WAIT: begin
						if (operand_done) begin
							state_q <= HT_SAMPLE;
							cnt_q   <= '0;
						end
					end
					default: begin
						state_q   <= HT_IDLE;
						holding_q <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule : dmae_hold_timer

/* File: dmae_top_properties.sv */
/*
 * Port-level checker for the DMA control block.
 * Assumes it is bound to dmae_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module dmae_chk
	import dmae_pkg::*;
#(
	parameter int NCH = 4
) (
	// Clock and reset.
	input wire logic                      CLK_SYS,
	input wire logic                      SYS_RST,
	// Register access.
	input wire logic                      REG_WR,
	input wire logic                      REG_RD,
	input wire logic [7:0]                REG_RDATA,
	input wire logic                      REG_ACK,
	// Channel side.
	input wire dmae_irq_src_s [NCH-1:0]   CH_IRQ_SRC,
	input wire logic [NCH-1:0]            CH_HOLD_MODE,
	input wire logic [NCH-1:0]            DMA_REQ,
	input wire logic                      SERVE_READY,
	input wire logic                      OPERAND_DONE,
	input wire logic                      GRANT_VALID,
	input wire logic [1:0]                GRANT_CH,
	input wire logic                      BUS_HOLD,
	input wire logic                      BUS_RELEASE,
	// Interrupts.
	input wire logic [2:0]                BOARD_IRQ_LEVEL,
	input wire logic                      IACK_STROBE,
	input wire logic [2:0]                IACK_LEVEL,
	input wire logic                      IACK_DONE,
	input wire logic                      PORTA_STATUS_IRQ
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	logic irq_a;
	assign irq_a = CH_IRQ_SRC[1].channel_irq_enable && (CH_IRQ_SRC[1].operation_complete_flag
		|| CH_IRQ_SRC[1].block_termination_flag || (CH_IRQ_SRC[1].peripheral_line_transition_flag
		&& CH_IRQ_SRC[1].peripheral_control_line_is_irq));
	sequence seq_access;
		(REG_RD || REG_WR) ##1 REG_ACK;
	endsequence
	sequence seq_hold_kept;
		(BUS_HOLD && !BUS_RELEASE)[*8];
	endsequence
	a_reg_ack_follows: assert property ((REG_RD || REG_WR) |-> seq_access)
		else $error("register access not acknowledged");
	a_ack_has_cause: assert property (REG_ACK |-> $past(REG_RD || REG_WR))
		else $error("acknowledge without access");
	a_rdata_idle_zero: assert property (!REG_ACK |-> REG_RDATA == 8'h00)
		else $error("read data outside acknowledge");
	a_grant_has_cause: assert property (GRANT_VALID |-> $past(SERVE_READY && (|DMA_REQ)))
		else $error("grant without request");
	a_grant_to_req: assert property (GRANT_VALID |-> (($past(DMA_REQ) >> GRANT_CH) & 1) != 0)
		else $error("grant to idle channel");
	a_iack_level_match: assert property (IACK_DONE |-> $past(IACK_STROBE && IACK_LEVEL == BOARD_IRQ_LEVEL
		&& BOARD_IRQ_LEVEL != 3'h0))
		else $error("acknowledge passed on wrong level");
	a_iack_refused: assert property (IACK_STROBE && IACK_LEVEL != BOARD_IRQ_LEVEL |=> !IACK_DONE)
		else $error("mismatched acknowledge answered");
	a_porta_irq_src: assert property (!SYS_RST |=> PORTA_STATUS_IRQ == $past(irq_a))
		else $error("port one status request wrong");
	a_hold_after_op: assert property (OPERAND_DONE && (|CH_HOLD_MODE) |=> BUS_HOLD)
		else $error("bus not held after operand");
	a_hold_min_time: assert property ($rose(BUS_HOLD) |-> seq_hold_kept)
		else $error("bus released too early");
	a_release_ends_hold: assert property (BUS_RELEASE |-> !BUS_HOLD && $past(BUS_HOLD))
		else $error("release without hold");
endmodule : dmae_chk

/* File: dmae_tlc_model.sv */
/*
 * Behavioural talker/listener controller: raises DMA requests and ends an operand after each grant.
 * Assumes the bench pulses want for one cycle per new request.
 */
`timescale 1ns/1ps
module dmae_tlc_model (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst,
	// Stimulus and grant.
	input  wire logic [3:0] want,
	input  wire logic       grant_valid,
	input  wire logic [1:0] grant_ch,
	// Requests.
	output logic [3:0]      dma_req,
	output logic            operand_done
);
	// A request stands until its channel is granted once.
	always_ff @(posedge clk) begin
		if (rst) begin
			dma_req <= 4'h0;
		end else begin
			dma_req <= (dma_req | want) & ~(grant_valid ? 4'h1 << grant_ch : 4'h0);
		end
	end
	always_ff @(posedge clk) begin
		operand_done <= !rst && grant_valid;
	end
endmodule : dmae_tlc_model

/* File: dma_error_priority_irq_ctrl_bench.sv */
/*
 * Self-checking bench for dmae_top with a request-side model.
 * Assumes the checker and the model files are compiled before this one.
 */
`timescale 1ns/1ps
`include "dmae_consts.svh"
module dma_error_priority_irq_ctrl_bench;
	import dmae_pkg::*;
	logic CLK_SYS = 1'h0, SYS_RST = 1'h1, REG_WR = 1'h0, REG_RD = 1'h0, REG_ACK;
	logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, IACK_DATA;
	logic [3:0] CH_ERR_FLAG = 4'h0, CH_HOLD_MODE = 4'h0, DMA_REQ, want = 4'h0;
	dmae_err_s [3:0] CH_ERR_CAUSE = '0;
	dmae_irq_src_s [3:0] CH_IRQ_SRC = '0;
	logic SERVE_READY = 1'h0, OPERAND_DONE, GRANT_VALID, BUS_HOLD, BUS_RELEASE, IACK_STROBE = 1'h0;
	logic [1:0] GRANT_CH, IACK_CH, t;
	logic [2:0] BOARD_IRQ_LEVEL = 3'h0, IACK_LEVEL = 3'h0;
	logic IRQ_PENDING, IACK_DONE, PORTA_STATUS_IRQ, PORTB_STATUS_IRQ;
	logic [4:0] e;
	logic [4:0] ec [8] = '{5'h00, 5'h01, 5'h02, 5'h00, 5'h00, 5'h00, 5'h10, 5'h11};
	int failures = 0, n_tests = 0, cyc = 0;
	dmae_top uut (.*);
	dmae_tlc_model tlc (.clk(CLK_SYS), .rst(SYS_RST), .want(want), .grant_valid(GRANT_VALID),
		.grant_ch(GRANT_CH), .dma_req(DMA_REQ), .operand_done(OPERAND_DONE));
	initial begin
		forever #5 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 12000) begin
			failures++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict
	task automatic check(input string name, input logic [7:0] x, input logic [7:0] got);
		n_tests++;
		if (got !== x) begin
			failures++;
			$display("Error %s expected %h seen %h", name, x, got);
		end
	endtask : check
	task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(negedge CLK_SYS);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = w;
		REG_RD = !w;
		@(negedge CLK_SYS);
		REG_WR = 1'h0;
		REG_RD = 1'h0;
		check("ack", 8'h01, {7'h00, REG_ACK});
	endtask : access
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
		access(a, 8'h00, 1'h0);
		check("read data", x, REG_RDATA);
	endtask : rd_chk
	task automatic serve(input logic [3:0] w, input logic [1:0] ch);
		@(negedge CLK_SYS);
		want = w;
		@(negedge CLK_SYS);
		want = 4'h0;
		SERVE_READY = 1'h1;
		@(negedge CLK_SYS);
		SERVE_READY = 1'h0;
		check("grant", {1'h1, 5'h00, ch}, {GRANT_VALID, 5'h00, GRANT_CH});
	endtask : serve
	task automatic iack(input logic [2:0] lvl, input logic [8:0] x);
		@(negedge CLK_SYS);
		IACK_LEVEL = lvl;
		IACK_STROBE = 1'h1;
		@(negedge CLK_SYS);
		IACK_STROBE = 1'h0;
		check("ack done", {7'h00, x[8]}, {7'h00, IACK_DONE});
		if (x[8]) check("vector", x[7:0], IACK_DATA);
	endtask : iack
	task automatic hold_run(input logic [3:0] general_hold_control, input logic [3:0] mode, input int ticks);
		int n = 0;
		access(8'hFF, {4'h0, general_hold_control}, 1'h1);
		CH_HOLD_MODE = mode;
		serve(4'h1, 2'h0);
		repeat (2) @(negedge CLK_SYS);
		check("hold", 8'h01, {7'h00, BUS_HOLD});
		while (BUS_HOLD === 1'h1 && n < 3000) begin
			@(negedge CLK_SYS);
			n++;
		end
		check("release", 8'h01, {7'h00, BUS_RELEASE});
		check("interval", 8'h01, {7'h00, n > ticks * 25 / 2 - 24 && n < ticks * 25 / 2 + 20});
	endtask : hold_run
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(negedge CLK_SYS);
		SYS_RST = 1'h0;
		for (int c = 0; c < 4; c++) begin
			rd_chk({2'(c), `DMAE_OFS_NORMAL_VEC}, 8'h0F);
			rd_chk({2'(c), `DMAE_OFS_ERROR_VEC}, 8'h0F);
			rd_chk({2'(c), `DMAE_OFS_PRIORITY}, 8'h00);
			rd_chk({2'(c), `DMAE_OFS_ERR_CODE}, 8'h00);
			access({2'(c), `DMAE_OFS_NORMAL_VEC}, 8'h40 | 8'(c), 1'h1);
			access({2'(c), `DMAE_OFS_ERROR_VEC}, 8'h80 | 8'(c), 1'h1);
			rd_chk({2'(c), `DMAE_OFS_ERROR_VEC}, 8'h80 | 8'(c));
		end
		access(8'hFF, 8'hFF, 1'h1);
		rd_chk(8'hFF, 8'h0F);
		access(8'h01, 8'hFF, 1'h1);
		rd_chk(8'h01, 8'h00);
		access(8'hED, 8'hFF, 1'h1);
		rd_chk(8'hED, 8'h03);
		rd_chk(8'h3E, 8'h00);
		for (int k = 0; k < 8; k++) begin
			t = 2'(k % 3 + 1);
			e = (k >= 3 && k <= 5) ? {3'(k - 2), t} : ec[k];
			CH_ERR_CAUSE[2] = '{cause: dmae_cause_e'(k), target: t};
			CH_ERR_FLAG[2] = 1'h1;
			@(negedge CLK_SYS);
			rd_chk(8'h81, {3'h0, e});
			CH_ERR_CAUSE[2] = '0;
			rd_chk(8'h81, {3'h0, e});
			CH_ERR_FLAG[2] = 1'h0;
			rd_chk(8'h81, 8'h00);
		end
		access(8'h2D, 8'h01, 1'h1);
		access(8'h6D, 8'h01, 1'h1);
		access(8'hAD, 8'h03, 1'h1);
		access(8'hED, 8'h00, 1'h1);
		serve(4'hF, 2'h2);
		serve(4'h0, 2'h0);
		serve(4'h1, 2'h1);
		serve(4'h0, 2'h0);
		serve(4'h0, 2'h3);
		BOARD_IRQ_LEVEL = 3'h3;
		CH_IRQ_SRC[3] = 5'h11;
		repeat (2) @(negedge CLK_SYS);
		check("port two irq", 8'h01, {7'h00, PORTB_STATUS_IRQ});
		check("irq pending", 8'h01, {7'h00, IRQ_PENDING});
		iack(3'h2, 9'h000);
		iack(3'h3, 9'h143);
		CH_ERR_FLAG[3] = 1'h1;
		iack(3'h3, 9'h183);
		CH_IRQ_SRC[1] = 5'h05;
		repeat (2) @(negedge CLK_SYS);
		check("port one irq", 8'h00, {7'h00, PORTA_STATUS_IRQ});
		CH_IRQ_SRC[1] = 5'h07;
		iack(3'h3, 9'h141);
		iack(3'h3, 9'h141);
		check("ack channel", 8'h01, {6'h00, IACK_CH});
		CH_IRQ_SRC = '0;
		CH_ERR_FLAG = 4'h0;
		hold_run(4'h0, 4'h1, 32);
		hold_run(4'h5, 4'h8, 128);
		print_verdict();
	end
endmodule : dma_error_priority_irq_ctrl_bench
bind dmae_top dmae_chk #(.NCH(NCH)) chk (.*);
